// ---- core/clve_pkg.sv ----
// Shared constants and types of the current-loop value encoder.
// Assumes a 125 MHz single clock and a 32-bit classic Wishbone slave port.
package clve_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int MAG_W = 12;
    localparam int RAW_W = 14;
    localparam int CH_MAX = 16;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Scale points, in units of 1/128 mA or 0.1 ohm
    // ------------------------------------------------------------
    localparam logic [RAW_W-1:0] LOOP_ZERO_UNITS = 14'h0200; // 4 mA
    localparam logic [RAW_W-1:0] LOOP_FULL_UNITS = 14'h0A00; // 20 mA
    localparam logic [RAW_W-1:0] RTD_RATED_MAX = 14'h0800;   // About 266 C
    localparam logic [RAW_W-1:0] SAT_LIMIT = 14'h1000;       // 4096 units
    localparam logic [MAG_W-1:0] MAG_ALL_ONES = 12'hFFF;

    // ------------------------------------------------------------
    // Measured-value word layout
    // ------------------------------------------------------------
    localparam int BIT_OVF = 0;
    localparam int BIT_ERR = 1;
    localparam int BIT_ACT = 2;
    localparam int MAG_LSB = 3;
    localparam int BIT_SIGN = 15;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CHAN_EN = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_VALUE_BASE = 8'h40;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RTD_OVER = 2;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_SHORT = 1;
    localparam int IRQ_NEW = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLVE_MODE_VOLT = 2'b00,
        CLVE_MODE_LOOP = 2'b01,
        CLVE_MODE_RTD = 2'b10
    } clve_mode_t;

    typedef enum logic [1:0] {
        CLVE_BUS_IDLE = 2'b00,
        CLVE_BUS_WAIT = 2'b01,
        CLVE_BUS_ACK = 2'b10
    } clve_bus_t;

    typedef struct packed {
        logic [3:0] chan;
        logic signed [RAW_W-1:0] raw;
        logic err;
    } clve_conv_t;

endpackage

// ---- core/clve_val_mem.sv ----
// Per-channel store of encoded measured-value words.
// Assumes one write and one read port on the same clock; read data registered.
`timescale 1ns/1ps
module clve_val_mem
    import clve_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int WIDTH = WORD_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad_size
        $error("DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage write and registered read
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rst_i)
        begin
            rd_data_o <= '0;
        end
        else
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule // clve_val_mem

// ---- core/clve_top.sv ----
// Current-loop value encoder: packs converted channel values into words.
// Assumes conversions arrive from logic on clk_i; the short pin is asynchronous.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module clve_top
    import clve_pkg::*;
#(
    parameter int NUM_CH = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Conversion results
    input wire logic conv_valid_i,
    input wire clve_conv_t conv_i,
    // Transducer short-circuit sense pin
    input wire logic short_sense_i,
    // Interrupt
    output logic irq_o
);

    localparam int CH_W = $clog2(NUM_CH) < 1 ? 1 : $clog2(NUM_CH);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NUM_CH < 2 || NUM_CH > CH_MAX || (1 << CH_W) != NUM_CH)
    begin : g_bad_ch
        $error("NUM_CH must be a power of two from 2 to 16");
    end

    typedef struct packed {
        clve_bus_t bus;
        logic ack;
        logic [31:0] rdata;
        clve_mode_t mode;
        logic rtd_over;
        logic [CH_MAX-1:0] chan_en;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic short_m;
        logic short_q;
        logic short_d;
        logic wr_vld;
        logic [3:0] wr_chan;
        logic [WORD_W-1:0] word;
    } clve_state_t;

    clve_state_t s;
    clve_state_t next_s;
    logic [WORD_W-1:0] mem_rd;
    logic [WORD_W-1:0] enc_word;
    logic bus_req;
    logic in_value;

    // ------------------------------------------------------------
    // Word encoder
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] encode(clve_conv_t c, clve_mode_t m,
                                                 logic rtd_ov, logic act, logic shrt);
        logic [WORD_W-1:0] w;
        logic neg;
        logic [RAW_W-1:0] mag;
        logic ovf;
        logic [MAG_W-1:0] mag12;
        w = '0;
        neg = c.raw[RAW_W-1] && (m == CLVE_MODE_VOLT);
        mag = c.raw[RAW_W-1] ? ((m == CLVE_MODE_VOLT) ? RAW_W'(-c.raw) : '0) : c.raw;
        ovf = 1'b0;
        mag12 = mag[MAG_W-1:0]; // Loop range passes units unchanged: 512..2560
        if (m == CLVE_MODE_RTD && !rtd_ov && mag > RTD_RATED_MAX)
        begin
            mag12 = RTD_RATED_MAX[MAG_W-1:0];
            ovf = 1'b1;
        end
        else if (mag >= SAT_LIMIT)
        begin
            mag12 = MAG_ALL_ONES;
            ovf = 1'b1;
        end
        w[BIT_SIGN] = neg;
        w[BIT_SIGN-1:MAG_LSB] = mag12;
        w[BIT_ACT] = act;
        w[BIT_ERR] = c.err && (m != CLVE_MODE_LOOP);
        w[BIT_OVF] = ovf || shrt;
        return w;
    endfunction

    assign enc_word = encode(conv_i, s.mode, s.rtd_over, s.chan_en[conv_i.chan], s.short_q);
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign in_value = (wb_adr_i >= REG_VALUE_BASE)
        && (wb_adr_i < REG_VALUE_BASE + 8'(NUM_CH * 4));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // Pin synchroniser
        next_s.short_m = short_sense_i;
        next_s.short_q = s.short_m;
        next_s.short_d = s.short_q;
        // Encode stage
        next_s.wr_vld = conv_valid_i;
        if (conv_valid_i)
        begin
            next_s.wr_chan = conv_i.chan;
            next_s.word = enc_word;
        end
        // Wishbone slave
        next_s.ack = 1'b0;
        case (s.bus)
            CLVE_BUS_IDLE:
            begin
                if (bus_req)
                begin
                    next_s.bus = CLVE_BUS_WAIT;
                end
            end
            CLVE_BUS_WAIT:
            begin
                next_s.ack = 1'b1;
                next_s.bus = CLVE_BUS_ACK;
                next_s.rdata = '0;
                if (in_value)
                begin
                    next_s.rdata = {16'h0000, mem_rd};
                end
                else
                begin
                    case (wb_adr_i)
                        REG_CTRL: next_s.rdata = {29'h0, s.rtd_over, s.mode};
                        REG_CHAN_EN: next_s.rdata = {16'h0000, s.chan_en};
                        REG_IRQ_STAT: next_s.rdata = {29'h0, s.irq_stat};
                        REG_IRQ_MASK: next_s.rdata = {29'h0, s.irq_mask};
                        REG_STATUS: next_s.rdata = {31'h0, s.short_q};
                        default: next_s.rdata = '0;
                    endcase
                end
                if (wb_we_i && wb_sel_i[0])
                begin
                    case (wb_adr_i)
                        REG_CTRL:
                        begin
                            next_s.mode = clve_mode_t'(wb_dat_i[CTRL_MODE_LSB +: 2]);
                            next_s.rtd_over = wb_dat_i[CTRL_RTD_OVER];
                        end
                        REG_CHAN_EN: next_s.chan_en[7:0] = wb_dat_i[7:0];
                        REG_IRQ_MASK: next_s.irq_mask = wb_dat_i[IRQ_W-1:0];
                        default: next_s.irq_mask = s.irq_mask;
                    endcase
                end
                if (wb_we_i && wb_sel_i[1] && wb_adr_i == REG_CHAN_EN)
                begin
                    next_s.chan_en[15:8] = wb_dat_i[15:8];
                end
            end
            CLVE_BUS_ACK:
            begin
                next_s.bus = CLVE_BUS_IDLE;
            end
            default:
            begin
                next_s.bus = CLVE_BUS_IDLE;
            end
        endcase
        // Sticky interrupt flags: write one clears, new event wins
        if (s.bus == CLVE_BUS_WAIT && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_IRQ_STAT)
        begin
            next_s.irq_stat = s.irq_stat & ~wb_dat_i[IRQ_W-1:0];
        end
        if (s.wr_vld && s.word[BIT_OVF])
        begin
            next_s.irq_stat[IRQ_OVF] = 1'b1;
        end
        if (s.short_q && !s.short_d)
        begin
            next_s.irq_stat[IRQ_SHORT] = 1'b1;
        end
        if (s.wr_vld)
        begin
            next_s.irq_stat[IRQ_NEW] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '{bus: CLVE_BUS_IDLE, mode: CLVE_MODE_LOOP, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Value store, read address taken from the bus
    clve_val_mem #(.DEPTH(NUM_CH), .WIDTH(WORD_W)) u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(s.wr_vld),
        .wr_addr_i(s.wr_chan[CH_W-1:0]),
        .wr_data_i(s.word),
        .rd_addr_i(wb_adr_i[CH_W+1:2]),
        .rd_data_o(mem_rd)
    );

    // Outputs
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign irq_o = |(s.irq_stat & s.irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_loop_units: assert property (conv_valid_i && s.mode == CLVE_MODE_LOOP
        && !conv_i.raw[RAW_W-1] && conv_i.raw < SAT_LIMIT
        |=> s.word[BIT_SIGN-1:MAG_LSB] == $past(conv_i.raw[MAG_W-1:0]))
        else $error("loop units not passed through");
    chk_loop_no_err: assert property (s.wr_vld && $past(s.mode) == CLVE_MODE_LOOP
        |-> !s.word[BIT_ERR])
        else $error("error flag set in loop range");
    chk_short_ovf: assert property (short_sense_i [*3] |=> s.word[BIT_OVF] || !s.wr_vld)
        else $error("short did not force overflow");
    chk_rtd_over: assert property (conv_valid_i && s.mode == CLVE_MODE_RTD && s.rtd_over
        && conv_i.raw > RTD_RATED_MAX && conv_i.raw < SAT_LIMIT && !s.short_q
        |=> !s.word[BIT_OVF] && s.word[BIT_SIGN-1:MAG_LSB] == $past(conv_i.raw[MAG_W-1:0]))
        else $error("thermometer overrange value limited");
    chk_rtd_clamp: assert property (conv_valid_i && s.mode == CLVE_MODE_RTD && !s.rtd_over
        && !conv_i.raw[RAW_W-1] && conv_i.raw > RTD_RATED_MAX
        |=> s.word[BIT_OVF] && s.word[BIT_SIGN-1:MAG_LSB] == RTD_RATED_MAX[MAG_W-1:0])
        else $error("thermometer value above rated range not clamped");
    chk_sign_bit: assert property (conv_valid_i
        |=> s.word[BIT_SIGN] == ($past(conv_i.raw[RAW_W-1]) && $past(s.mode) == CLVE_MODE_VOLT))
        else $error("sign bit wrong");
    chk_sat_ones: assert property (conv_valid_i && !conv_i.raw[RAW_W-1] && conv_i.raw >= SAT_LIMIT
        && s.mode != CLVE_MODE_RTD
        |=> s.word[BIT_SIGN-1:MAG_LSB] == MAG_ALL_ONES && s.word[BIT_OVF])
        else $error("magnitude not saturated");
    chk_ack_timing: assert property (s.bus == CLVE_BUS_IDLE && bus_req |=> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    chk_irq_level: assert property (s.wr_vld
        |=> s.irq_stat[IRQ_NEW] && (irq_o || !s.irq_mask[IRQ_NEW]))
        else $error("new word event lost or interrupt not raised");

    cov_loop_zero: cover property (conv_valid_i && s.mode == CLVE_MODE_LOOP
        && conv_i.raw == LOOP_ZERO_UNITS);
    cov_loop_full: cover property (conv_valid_i && s.mode == CLVE_MODE_LOOP
        && conv_i.raw == LOOP_FULL_UNITS);
    cov_short_irq: cover property (s.irq_stat[IRQ_SHORT] && irq_o);

endmodule // clve_top

// ---- testbench/clve_conv_src.sv ----
// Converter front end model: delivers channel results and the short pin.
// Assumes clk_i is the encoder clock; results are one-cycle pulses.
`timescale 1ns/1ps
module clve_conv_src
    import clve_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Conversion results
    output logic conv_valid_o,
    output clve_conv_t conv_o,
    // Short-circuit sense
    output logic short_o
);
    initial
    begin
        conv_valid_o = 1'b0;
        conv_o = '0;
        short_o = 1'b0;
    end

    // One result pulse, then fields scrambled so stale data never matches
    task automatic send(input logic [3:0] ch, input logic [13:0] raw, input logic err);
        @(posedge clk_i);
        conv_valid_o <= 1'b1;
        conv_o <= '{chan: ch, raw: raw, err: err};
        @(posedge clk_i);
        conv_valid_o <= 1'b0;
        conv_o <= '{chan: ~ch, raw: ~raw, err: ~err};
        repeat (3) @(posedge clk_i);
    endtask

    // Shorted transducer level, held as long as the current flows
    task automatic set_short(input logic lvl);
        @(posedge clk_i);
        short_o <= lvl;
        repeat (5) @(posedge clk_i);
    endtask
endmodule // clve_conv_src

// ---- testbench/clve_top_bench.sv ----
// Self-checking bench for the encoder: Wishbone tasks plus result tables.
// Assumes a two-edge register answer and a two-edge conversion store.
`timescale 1ns/1ps
module clve_top_bench
    import clve_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, irq_o, conv_valid_i, short_sense_i;
    clve_conv_t conv_i;
    int error_cnt = 0;
    int n_compared = 0;
    logic [1:0] t_ctrl [12] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h0, 2'h1, 2'h1};
    logic [13:0] t_raw [12] = '{14'h0200, 14'h0A00, 14'h012C, 14'h0FFF, 14'h1000,
        14'h0BB8, 14'h0800, 14'h0BB8, 14'h1000, 14'h3FFB, 14'h3FFB, 14'h0200};
    logic [15:0] seen [12];
    logic [15:0] t_exp [12] = '{16'h1004, 16'h5004, 16'h0964, 16'h7FFC, 16'h7FFD,
        16'h4005, 16'h4004, 16'h5DC4, 16'h7FFD, 16'h802C, 16'h0004, 16'h1000};

    always #4 clk_i = ~clk_i;

    clve_top clve_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conv_valid_i(conv_valid_i), .conv_i(conv_i), .short_sense_i(short_sense_i),
        .irq_o(irq_o));
    clve_conv_src clve_conv_src_inst (.clk_i(clk_i), .conv_valid_o(conv_valid_i),
        .conv_o(conv_i), .short_o(short_sense_i));

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_dat_i <= ~d;
        if (n >= 20)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rd(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rd("ctrl reset", REG_CTRL, 32'h1);
        chk_rd("chan_en reset", REG_CHAN_EN, 32'h0);
        chk_rd("mask reset", REG_IRQ_MASK, 32'h0);
        chk_rd("stat reset", REG_IRQ_STAT, 32'h0);
        chk_rd("unmapped", 8'h20, 32'h0);
        $display("test reset done");
        // Encoding table, one channel per row; channel 11 left inactive
        wb_xfer(1'b1, REG_CHAN_EN, 32'h07FF);
        for (int i = 0; i < 12; i++)
        begin
            wb_xfer(1'b1, REG_CTRL, {29'h0, i == 7 || i == 8, t_ctrl[i]});
            clve_conv_src_inst.send(i[3:0], t_raw[i], i == 2);
            chk_rd("value word", REG_VALUE_BASE + 8'(4 * i), {16'h0, t_exp[i]});
            seen[i] = rd[15:0];
        end
        // Host side on words read back: zero base, overrange, open loop
        chk("zero based", 32'h0, 32'(seen[0][14:3]) - 32'h200);
        chk("overrange bits", 32'h1, 32'(seen[3][12] & seen[3][14]));
        chk("rated no overrange", 32'h0, 32'(seen[0][12] & seen[0][14]));
        chk("open loop", 32'h1, 32'(seen[2][14:3] < 12'h180));
        chk("closed loop", 32'h0, 32'(seen[0][14:3] < 12'h180));
        wb_xfer(1'b1, REG_VALUE_BASE, 32'hFFFF);
        chk_rd("value read only", REG_VALUE_BASE, 32'h1004);
        $display("test encode done");
        // Interrupt status, mask and clear
        chk_rd("stat events", REG_IRQ_STAT, 32'h5);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wb_xfer(1'b1, REG_IRQ_MASK, 32'h4);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        wb_xfer(1'b1, REG_IRQ_STAT, 32'h7);
        chk_rd("stat cleared", REG_IRQ_STAT, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        $display("test irq done");
        // Shorted transducer forces overflow on a channel 3 result
        wb_xfer(1'b1, REG_CTRL, 32'h1);
        clve_conv_src_inst.set_short(1'b1);
        chk_rd("short status", REG_STATUS, 32'h1);
        clve_conv_src_inst.send(4'h3, 14'd1000, 1'b0);
        chk_rd("short word", REG_VALUE_BASE + 8'h0C, 32'h1F45);
        chk_rd("short stat", REG_IRQ_STAT, 32'h7);
        clve_conv_src_inst.set_short(1'b0);
        clve_conv_src_inst.send(4'h3, 14'd1000, 1'b0);
        chk_rd("after short", REG_VALUE_BASE + 8'h0C, 32'h1F44);
        $display("test short done");
        wrap_up();
    end
endmodule // clve_top_bench
